/* File: core/idle_wakeup_pkg.sv */
// Constants for the idle, wakeup and interrupt controller
package idle_wakeup_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] INT_ENABLE_OFFSET = 8'h04;
	localparam logic [7:0] INT_PENDING_OFFSET = 8'h08;
	localparam logic [7:0] WAKE_ENABLE_OFFSET = 8'h0C;
	localparam logic [7:0] WAKE_EDGE_OFFSET = 8'h10;
	localparam logic [7:0] WAKE_PENDING_OFFSET = 8'h14;
	localparam logic [7:0] STATUS_OFFSET = 8'h18;
	localparam logic [7:0] TIMER_OFFSET = 8'h1C;

	// Control register fields
	localparam int GLOBAL_INT_ENABLE_BIT = 0;
	localparam int IDLE_REQUEST_BIT = 1;
	localparam int HALT_REQUEST_BIT = 2;

	// Maskable sources, index order is rank order (0 highest)
	localparam int NUM_SOURCES = 6;
	localparam int SRC_EXTERNAL = 0;
	localparam int SRC_IDLE_TIMER = 1;
	localparam int SRC_TIMER_A = 2;
	localparam int SRC_TIMER_B = 3;
	localparam int SRC_SERIAL = 4;
	localparam int SRC_WAKEUP = 5;

	// Status register fields
	localparam int STAT_IDLE_BIT = 0;
	localparam int STAT_HALT_BIT = 1;
	localparam int STAT_TRAP_ACTIVE_BIT = 2;
	localparam int STAT_TRAP_PENDING_BIT = 3;
	localparam int STAT_WINNER_LSB = 4;

	// Reset values
	localparam logic [NUM_SOURCES-1:0] INT_ENABLE_RESET = 6'h00;
	localparam logic [NUM_SOURCES-1:0] INT_PENDING_RESET = 6'h00;
	localparam logic [7:0] WAKE_ENABLE_RESET = 8'h00;
	localparam logic [7:0] WAKE_EDGE_RESET = 8'h00;
	localparam logic [7:0] WAKE_PENDING_RESET = 8'h00;

	// Idle timer
	localparam int IDLE_TIMER_WIDTH = 16;
	localparam int IDLE_TOGGLE_BIT = 12;

	// Acknowledge sequence
	localparam logic [14:0] SERVICE_ADDR = 15'h00FF;
	localparam logic [2:0] ACK_CYCLES = 3'h7;
	localparam logic [2:0] WINNER_NONE = 3'h7;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_ACK,
		MODE_IDLE,
		MODE_HALT
	} mode_t;

endpackage

/* File: core/idle_wakeup_interrupt_ctrl.sv */
// Idle mode, pin wakeup and interrupt controller with one fixed service address
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module idle_wakeup_interrupt_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Wakeup pins
	input wire logic [7:0] wakePins,
	// Other maskable sources, one-cycle pulses
	input wire logic extEvent,
	input wire logic timerAEvent,
	input wire logic timerBEvent,
	input wire logic serialEvent,
	// CPU sequencer
	input wire logic instrStart,
	input wire logic skipCurrent,
	input wire logic softTrap,
	input wire logic returnFromInterrupt,
	input wire logic [14:0] nextInstrAddr,
	output logic cpuRun,
	output logic ackBusy,
	output logic stackPush,
	output logic [14:0] stackPushAddr,
	output logic stackPop,
	output logic pcLoad,
	output logic [14:0] pcLoadAddr
);
	import idle_wakeup_pkg::*;

	function automatic logic [2:0] firstSet(input logic [NUM_SOURCES-1:0] v);
		logic [2:0] r;
		r = WINNER_NONE;
		for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// Bus state
	logic wrPend_q;
	logic [7:0] wrAddr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;

	// Control state
	mode_t mode_q, mode_d;
	logic [2:0] ackCnt_q, ackCnt_d;
	logic globalEnable_q, globalEnable_d;
	logic trapPending_q, trapPending_d;
	logic trapActive_q, trapActive_d;
	logic [NUM_SOURCES-1:0] intEnable_q, intEnable_d;
	logic [NUM_SOURCES-1:0] intPending_q, intPending_d;
	logic [7:0] wakeEnable_q, wakeEnable_d;
	logic [7:0] wakeEdge_q, wakeEdge_d;
	logic [7:0] wakePending_q, wakePending_d;
	logic [IDLE_TIMER_WIDTH-1:0] idleTimer_q;
	logic [14:0] savedAddr_q;

	// Pin synchronisers and filtered level
	logic [7:0] pinS1_q, pinS2_q, pinS3_q, pinLevel_q;

	// Output registers
	logic cpuRun_q, ackBusy_q, stackPush_q, stackPop_q, pcLoad_q;
	logic [14:0] pcLoadAddr_q;

	// Address phase decode
	wire addrPhase = hsel & hready & htrans[1];
	wire rdStart = addrPhase & ~hwrite;
	wire wrStart = addrPhase & hwrite;

	// Data phase write strobes
	wire wrCtrl = wrPend_q & (wrAddr_q == CTRL_OFFSET);
	wire wrIntEn = wrPend_q & (wrAddr_q == INT_ENABLE_OFFSET);
	wire wrIntPnd = wrPend_q & (wrAddr_q == INT_PENDING_OFFSET);
	wire wrWakeEn = wrPend_q & (wrAddr_q == WAKE_ENABLE_OFFSET);
	wire wrWakeEdge = wrPend_q & (wrAddr_q == WAKE_EDGE_OFFSET);
	wire wrWakePnd = wrPend_q & (wrAddr_q == WAKE_PENDING_OFFSET);

	// A pin change counts once second and third stage agree
	wire [7:0] pinStable = ~(pinS2_q ^ pinS3_q);
	wire [7:0] pinNew = (pinS3_q & pinStable) | (pinLevel_q & ~pinStable);
	wire [7:0] pinRise = pinNew & ~pinLevel_q;
	wire [7:0] pinFall = ~pinNew & pinLevel_q;
	wire [7:0] pinEdge = (wakeEdge_q & pinFall) | (~wakeEdge_q & pinRise);
	wire wakeEvent = |(pinEdge & wakeEnable_q);

	wire timerRun = (mode_q != MODE_HALT);
	wire [IDLE_TIMER_WIDTH-1:0] idleTimerNext =
		timerRun ? idleTimer_q + 1'b1 : idleTimer_q;
	wire timerToggle = idleTimerNext[IDLE_TOGGLE_BIT] ^
		idleTimer_q[IDLE_TOGGLE_BIT];

	// Events entering the maskable pending register
	// wakeup pins also act as interrupt source
	wire [NUM_SOURCES-1:0] srcEvent = {
		|pinEdge, serialEvent, timerBEvent, timerAEvent,
		timerToggle, extEvent};

	wire [NUM_SOURCES-1:0] srcActive = intPending_q & intEnable_q;
	wire maskableReq = globalEnable_q & ~trapActive_q & (|srcActive);
	wire [2:0] winner = firstSet(srcActive);
	// no acknowledge on a skipped instruction
	wire ackStart = (mode_q == MODE_RUN) & instrStart & ~skipCurrent &
		(trapPending_q | maskableReq);
	// halt refused on enabled pending wakeup
	wire haltBlocked = |(wakeEnable_q & wakePending_q);

	// Register read mux
	wire [31:0] statusWord = {25'h0, winner, trapPending_q, trapActive_q,
		mode_q == MODE_HALT, mode_q == MODE_IDLE};
	wire [31:0] ctrlWord = {31'h0, globalEnable_q};
	wire [7:0] rdOff = haddr[7:0];
	wire mappedRead = (haddr[31:8] == 24'h0) & (rdOff[1:0] == 2'h0);
	// Read address decode
	wire rdCtrl = mappedRead & (rdOff == CTRL_OFFSET);
	wire rdIntEn = mappedRead & (rdOff == INT_ENABLE_OFFSET);
	wire rdIntPnd = mappedRead & (rdOff == INT_PENDING_OFFSET);
	wire rdWakeEn = mappedRead & (rdOff == WAKE_ENABLE_OFFSET);
	wire rdWakeEdge = mappedRead & (rdOff == WAKE_EDGE_OFFSET);
	wire rdWakePnd = mappedRead & (rdOff == WAKE_PENDING_OFFSET);
	wire rdStatus = mappedRead & (rdOff == STATUS_OFFSET);
	wire rdTimer = mappedRead & (rdOff == TIMER_OFFSET);
	wire [31:0] readWord =
		rdCtrl ? ctrlWord :
		rdIntEn ? {26'h0, intEnable_q} :
		rdIntPnd ? {26'h0, intPending_q} :
		rdWakeEn ? {24'h0, wakeEnable_q} :
		rdWakeEdge ? {24'h0, wakeEdge_q} :
		rdWakePnd ? {24'h0, wakePending_q} :
		rdStatus ? statusWord :
		rdTimer ? {16'h0, idleTimer_q} : 32'h0;

	// Control and pending next state
	always_comb begin
		mode_d = mode_q;
		ackCnt_d = ackCnt_q;
		globalEnable_d = globalEnable_q;
		trapPending_d = trapPending_q | softTrap;
		trapActive_d = trapActive_q;
		intEnable_d = intEnable_q;
		intPending_d = intPending_q;
		wakeEnable_d = wakeEnable_q;
		wakeEdge_d = wakeEdge_q;
		wakePending_d = wakePending_q;
		if (wrCtrl) begin
			// global enable writable at any time
			globalEnable_d = hwdata[GLOBAL_INT_ENABLE_BIT];
		end
		if (wrIntEn) begin
			// timer enable lives in this register
			intEnable_d = hwdata[NUM_SOURCES-1:0];
		end
		if (wrWakeEn) begin
			wakeEnable_d = hwdata[7:0];
		end
		if (wrWakeEdge) begin
			wakeEdge_d = hwdata[7:0];
		end
		// write zero clears, new event wins
		if (wrIntPnd) begin
			intPending_d = intPending_q & hwdata[NUM_SOURCES-1:0];
		end
		intPending_d = intPending_d | srcEvent;
		if (wrWakePnd) begin
			wakePending_d = wakePending_q & hwdata[7:0];
		end
		wakePending_d = wakePending_d | pinEdge;
		// return restores global enable, ends trap
		if (returnFromInterrupt) begin
			globalEnable_d = 1'b1;
			trapActive_d = 1'b0;
		end
		unique case (mode_q)
			MODE_RUN: begin
				if (ackStart) begin
					if (trapPending_q) begin
						trapPending_d = softTrap;
						trapActive_d = 1'b1;
					end
					globalEnable_d = 1'b0;
					ackCnt_d = ACK_CYCLES - 3'h1;
					mode_d = MODE_ACK;
				end else if (wrCtrl & hwdata[HALT_REQUEST_BIT]) begin
					if (!haltBlocked) begin
						mode_d = MODE_HALT;
					end
				end else if (wrCtrl & hwdata[IDLE_REQUEST_BIT]) begin
					mode_d = MODE_IDLE;
				end
			end
			MODE_ACK: begin
				if (ackCnt_q == 3'h1) begin
					mode_d = MODE_RUN;
				end
				ackCnt_d = ackCnt_q - 3'h1;
			end
			MODE_IDLE: begin
				// leave idle on toggle or wake edge
				// interrupt logic decides the return path
				if (timerToggle | wakeEvent) begin
					mode_d = MODE_RUN;
				end
			end
			MODE_HALT: begin
				if (wakeEvent) begin
					mode_d = MODE_RUN;
				end
			end
		endcase
	end

	// Bus registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
			hrdata_q <= 32'h0;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			wrPend_q <= wrStart & (haddr[31:8] == 24'h0);
			wrAddr_q <= haddr[7:0];
			hrdata_q <= rdStart ? readWord : 32'h0;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	// Pin synchronisers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pinS1_q <= 8'h00;
			pinS2_q <= 8'h00;
			pinS3_q <= 8'h00;
			pinLevel_q <= 8'h00;
		end else begin
			pinS1_q <= wakePins;
			pinS2_q <= pinS1_q;
			pinS3_q <= pinS2_q;
			pinLevel_q <= pinNew;
		end
	end

	// Mode, acknowledge and trap state
	// reset clears global enable
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= MODE_RUN;
			ackCnt_q <= 3'h0;
			globalEnable_q <= 1'b0;
			trapPending_q <= 1'b0;
			trapActive_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			ackCnt_q <= ackCnt_d;
			globalEnable_q <= globalEnable_d;
			trapPending_q <= trapPending_d;
			trapActive_q <= trapActive_d;
		end
	end

	// Maskable enables and pending flags
	// reset clears enables and pending
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			intEnable_q <= INT_ENABLE_RESET;
			intPending_q <= INT_PENDING_RESET;
		end else begin
			intEnable_q <= intEnable_d;
			intPending_q <= intPending_d;
		end
	end

	// Wakeup registers
	// reset clears wakeup enable and edge select
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wakeEnable_q <= WAKE_ENABLE_RESET;
			wakeEdge_q <= WAKE_EDGE_RESET;
			wakePending_q <= WAKE_PENDING_RESET;
		end else begin
			wakeEnable_q <= wakeEnable_d;
			wakeEdge_q <= wakeEdge_d;
			wakePending_q <= wakePending_d;
		end
	end

	// Idle timer, free running except in halt
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			idleTimer_q <= '0;
		end else begin
			idleTimer_q <= idleTimerNext;
		end
	end

	// Run and acknowledge status
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cpuRun_q <= 1'b1;
			ackBusy_q <= 1'b0;
		end else begin
			// core stalled in idle and halt
			cpuRun_q <= (mode_d == MODE_RUN);
			ackBusy_q <= (mode_d == MODE_ACK);
		end
	end

	// Stack handshakes
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stackPush_q <= 1'b0;
			stackPop_q <= 1'b0;
			savedAddr_q <= 15'h0;
		end else begin
			// push next address at acknowledge start
			stackPush_q <= ackStart;
			if (ackStart) begin
				savedAddr_q <= nextInstrAddr;
			end
			stackPop_q <= returnFromInterrupt;
		end
	end

	// Service jump
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pcLoad_q <= 1'b0;
			pcLoadAddr_q <= SERVICE_ADDR;
		end else begin
			// jump in the last acknowledge cycle
			pcLoad_q <= (mode_q == MODE_ACK) & (ackCnt_q == 3'h2);
			pcLoadAddr_q <= SERVICE_ADDR;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign cpuRun = cpuRun_q;
	assign ackBusy = ackBusy_q;
	assign stackPush = stackPush_q;
	assign stackPushAddr = savedAddr_q;
	assign stackPop = stackPop_q;
	assign pcLoad = pcLoad_q;
	assign pcLoadAddr = pcLoadAddr_q;

endmodule
`default_nettype wire

/* File: dv/idle_wakeup_props.sv */
// Port checker for the idle, wakeup and interrupt controller
`timescale 1ns/100ps
`default_nettype none
module idle_wakeup_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Bus response
	input wire logic hreadyout,
	input wire logic hresp,
	// CPU sequencer
	input wire logic instrStart,
	input wire logic skipCurrent,
	input wire logic returnFromInterrupt,
	input wire logic [14:0] nextInstrAddr,
	input wire logic cpuRun,
	input wire logic ackBusy,
	input wire logic stackPush,
	input wire logic [14:0] stackPushAddr,
	input wire logic stackPop,
	input wire logic pcLoad,
	input wire logic [14:0] pcLoadAddr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	AST_ACK_LEN: assert property ($rose(ackBusy) |-> ackBusy[*6])
		else $error("acknowledge too short");
	AST_ACK_PUSH: assert property ($rose(ackBusy) |-> stackPush)
		else $error("no push at acknowledge start");
	AST_ACK_PC: assert property ($rose(ackBusy) |-> ##5 pcLoad)
		else $error("jump not in last acknowledge cycle");
	AST_ACK_END: assert property ($fell(ackBusy) |-> $past(pcLoad))
		else $error("acknowledge ended without jump");
	AST_PC_ADDR: assert property (pcLoad |-> pcLoadAddr == 15'h00FF)
		else $error("jump address wrong");
	AST_PUSH_ADDR: assert property (stackPush |->
		stackPushAddr == $past(nextInstrAddr))
		else $error("pushed address wrong");
	AST_PUSH_CAUSE: assert property (stackPush |->
		$past(instrStart) && !$past(skipCurrent))
		else $error("acknowledge without instruction start");
	AST_SKIP: assert property (instrStart && skipCurrent |=> !stackPush)
		else $error("acknowledge on skipped instruction");
	AST_POP: assert property (returnFromInterrupt |=> stackPop)
		else $error("no pop after return");
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus response not ready or not okay");
	cover property ($rose(ackBusy));
	cover property (stackPop);
	cover property ($fell(cpuRun));
endmodule
bind idle_wakeup_interrupt_ctrl idle_wakeup_props idle_wakeup_props_i (
	.sys_clk(sys_clk), .resetn(resetn), .hreadyout(hreadyout),
	.hresp(hresp), .instrStart(instrStart), .skipCurrent(skipCurrent),
	.returnFromInterrupt(returnFromInterrupt),
	.nextInstrAddr(nextInstrAddr), .cpuRun(cpuRun), .ackBusy(ackBusy),
	.stackPush(stackPush), .stackPushAddr(stackPushAddr),
	.stackPop(stackPop), .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr));
`default_nettype wire

/* File: dv/cpu_seq_model.sv */
// Behavioural CPU sequencer and port pins
`timescale 1ns/100ps
`default_nettype none
module cpu_seq_model (
	// Clock
	input wire logic sys_clk,
	// Sequencer
	output logic instrStart,
	output logic skipCurrent,
	output logic softTrap,
	output logic returnFromInterrupt,
	output logic [14:0] nextInstrAddr,
	// Port pins
	output logic [7:0] wakePins
);
	initial begin
		{instrStart, skipCurrent, softTrap, returnFromInterrupt} = 4'h0;
		nextInstrAddr = 15'h0100;
		wakePins = 8'h00;
	end
	// One slot: start, skip, trap, return
	task op(input logic [3:0] k);
		@(posedge sys_clk);
		{instrStart, skipCurrent, softTrap, returnFromInterrupt} <= k;
		@(posedge sys_clk);
		{instrStart, skipCurrent, softTrap, returnFromInterrupt} <= 4'h0;
		nextInstrAddr <= nextInstrAddr + 15'h0001;
	endtask
	task setPins(input logic [7:0] v);
		@(posedge sys_clk);
		wakePins <= v;
	endtask
endmodule
`default_nettype wire

/* File: dv/idle_wakeup_interrupt_ctrl_test.sv */
// Register and sequencer tests for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module idle_wakeup_interrupt_ctrl_test;
	import idle_wakeup_pkg::*;
	logic sys_clk, resetn, hsel, hwrite, hreadyout, hresp;
	logic cpuRun, ackBusy, stackPush, stackPop, pcLoad;
	logic instrStart, skipCurrent, softTrap, returnFromInterrupt;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] evt;
	logic [7:0] wakePins;
	logic [14:0] nextInstrAddr, stackPushAddr, pcLoadAddr;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0] rstOffs [6] = '{CTRL_OFFSET, INT_ENABLE_OFFSET,
		INT_PENDING_OFFSET, WAKE_ENABLE_OFFSET, WAKE_EDGE_OFFSET,
		WAKE_PENDING_OFFSET};
	int nTests, failures, n;
	idle_wakeup_interrupt_ctrl idle_wakeup_interrupt_ctrl_i (
		.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .wakePins(wakePins), .extEvent(evt[0]),
		.timerAEvent(evt[1]), .timerBEvent(evt[2]), .serialEvent(evt[3]),
		.instrStart(instrStart), .skipCurrent(skipCurrent),
		.softTrap(softTrap), .returnFromInterrupt(returnFromInterrupt),
		.nextInstrAddr(nextInstrAddr), .cpuRun(cpuRun), .ackBusy(ackBusy),
		.stackPush(stackPush), .stackPushAddr(stackPushAddr),
		.stackPop(stackPop), .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr));
	cpu_seq_model cpu_seq_model_i (.sys_clk(sys_clk),
		.instrStart(instrStart), .skipCurrent(skipCurrent),
		.softTrap(softTrap), .returnFromInterrupt(returnFromInterrupt),
		.nextInstrAddr(nextInstrAddr), .wakePins(wakePins));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task pulse(input logic [3:0] v);
		@(posedge sys_clk);
		evt <= v;
		@(posedge sys_clk);
		evt <= 4'h0;
	endtask
	// Instruction slot, then acknowledge seen or not
	task ack(input logic [3:0] k, input logic e);
		cpu_seq_model_i.op(k);
		#1;
		chk({31'h0, ackBusy}, {31'h0, e});
	endtask
	task print_verdict;
		$display("checks %0d failures %0d", nTests, failures);
		if (failures == 0 && nTests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge sys_clk);
		failures++;
		print_verdict();
	end
	initial begin
		{resetn, hsel, hwrite, htrans, hwdata, haddr, evt} = '0;
		hsize = 3'h2;
		nTests = 0;
		failures = 0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		foreach (rstOffs[i]) rdc(rstOffs[i], 32'h0); // cleared
		wr(8'h02, 32'hFFFFFFFF);
		rdc(8'h02, 32'h0);
		rdc(CTRL_OFFSET, 32'h0);
		pulse(4'h9);
		wr(INT_ENABLE_OFFSET, 32'h3F);
		ack(4'h8, 1'b0); // gated
		rdc(STATUS_OFFSET, 32'h0); // rank
		rdc(INT_PENDING_OFFSET, 32'h11); // held
		wr(CTRL_OFFSET, 32'h1);
		ack(4'hC, 1'b0); // skip
		ack(4'h8, 1'b1); // taken
		rdc(CTRL_OFFSET, 32'h0); // cleared
		repeat (8) @(posedge sys_clk);
		wr(INT_PENDING_OFFSET, 32'h3E);
		rdc(STATUS_OFFSET, 32'h40); // next
		wr(CTRL_OFFSET, 32'h1);
		ack(4'h8, 1'b1); // nested
		repeat (8) @(posedge sys_clk);
		cpu_seq_model_i.op(4'h1);
		rdc(CTRL_OFFSET, 32'h1); // return
		wr(INT_PENDING_OFFSET, 32'h0);
		rdc(INT_PENDING_OFFSET, 32'h0); // cleared
		pulse(4'h6);
		rdc(INT_PENDING_OFFSET, 32'h0C); // timer sources
		rdc(STATUS_OFFSET, 32'h20); // timer A first
		wr(INT_PENDING_OFFSET, 32'h0);
		cpu_seq_model_i.op(4'h2);
		rdc(STATUS_OFFSET, 32'h78); // trap
		ack(4'h8, 1'b1); // trap
		repeat (8) @(posedge sys_clk);
		rdc(STATUS_OFFSET, 32'h74); // serviced
		pulse(4'h1);
		wr(CTRL_OFFSET, 32'h1);
		ack(4'h8, 1'b0); // blocked
		cpu_seq_model_i.op(4'h1);
		ack(4'h8, 1'b1); // after return
		repeat (8) @(posedge sys_clk);
		wr(INT_PENDING_OFFSET, 32'h0);
		wr(WAKE_ENABLE_OFFSET, 32'h1);
		wr(WAKE_EDGE_OFFSET, 32'h2);
		rdc(WAKE_EDGE_OFFSET, 32'h2); // kept
		cpu_seq_model_i.setPins(8'h03);
		repeat (8) @(posedge sys_clk);
		rdc(WAKE_PENDING_OFFSET, 32'h1); // rising
		rdc(INT_PENDING_OFFSET, 32'h20); // pin source
		cpu_seq_model_i.setPins(8'h00);
		repeat (8) @(posedge sys_clk);
		rdc(WAKE_PENDING_OFFSET, 32'h3); // falling
		wr(CTRL_OFFSET, 32'h4);
		rdc(STATUS_OFFSET, 32'h50); // refused
		chk({31'h0, cpuRun}, 32'h1); // running
		wr(WAKE_PENDING_OFFSET, 32'h0);
		rdc(WAKE_PENDING_OFFSET, 32'h0); // cleared
		wr(INT_ENABLE_OFFSET, 32'h2);
		wr(INT_PENDING_OFFSET, 32'h0);
		wr(CTRL_OFFSET, 32'h3);
		repeat (3) @(posedge sys_clk);
		chk({31'h0, cpuRun}, 32'h0); // idle
		for (n = 0; n < 4200 && cpuRun !== 1'b1; n++) @(posedge sys_clk);
		chk({31'h0, cpuRun}, 32'h1); // timer exit
		rdc(INT_PENDING_OFFSET, 32'h2); // timer flag
		ack(4'h8, 1'b1); // service first
		repeat (8) @(posedge sys_clk);
		wr(INT_PENDING_OFFSET, 32'h0);
		wr(CTRL_OFFSET, 32'h2);
		repeat (3) @(posedge sys_clk);
		chk({31'h0, cpuRun}, 32'h0); // idle
		cpu_seq_model_i.setPins(8'h01);
		repeat (8) @(posedge sys_clk);
		chk({31'h0, cpuRun}, 32'h1); // pin exit
		ack(4'h8, 1'b0); // resume
		print_verdict();
	end
endmodule
`default_nettype wire
